// *** hdl/ddg_pkg.sv ***
package ddg_pkg;
    // apb register byte offsets
    localparam logic [7:0] DDG_REG_LIST_HEAD = 8'h00;
    localparam logic [7:0] DDG_REG_POLL = 8'h04;
    localparam logic [7:0] DDG_REG_CTRL = 8'h08;
    localparam logic [7:0] DDG_REG_STATUS = 8'h0C;
    localparam logic [7:0] DDG_REG_TXEVT = 8'h10;
    // ctrl bit positions
    localparam int DDG_CTRL_OPEN = 0;
    localparam int DDG_CTRL_PAUSE = 1;
    localparam int DDG_CTRL_RESUME = 2;
    localparam int DDG_CTRL_BURST_MODE = 3;
    localparam int DDG_CTRL_CLR_UNDERRUN = 4;
    localparam int DDG_CTRL_BAD_CRC_EN = 5;
    // status bit positions
    localparam int DDG_ST_DN_DONE = 0;
    localparam int DDG_ST_TX_DONE = 1;
    localparam int DDG_ST_TX_ERR = 2;
    localparam int DDG_ST_BUSY = 3;
    localparam int DDG_ST_PAUSED = 4;
    localparam int DDG_ST_UNDERRUN = 5;
    // descriptor layout
    localparam logic [31:0] DDG_OFS_LINK = 32'h0000_0000;
    localparam logic [31:0] DDG_OFS_HDR = 32'h0000_0004;
    localparam logic [31:0] DDG_OFS_FRAG = 32'h0000_0008;
    localparam int DDG_MAX_FRAGS = 63;
    localparam int DDG_HDR_LEN_MSB = 14;
    localparam int DDG_HDR_NO_CRC = 15;
    localparam int DDG_HDR_DONE = 16;
    localparam int DDG_HDR_TX_IRQ = 27;
    localparam int DDG_HDR_NO_PAYLOAD = 29;
    localparam int DDG_HDR_DN_IRQ = 31;
    localparam int DDG_LEN_LAST = 31;
    localparam logic [31:0] DDG_RESET_WORD = 32'h0000_0000;
    // poll timebase: one poll unit in ns, and in cycles at 5 ns
    localparam int DDG_CLK_NS = 5;
    localparam int DDG_POLL_UNIT_NS = 320;
    localparam int DDG_POLL_UNIT_CYC = DDG_POLL_UNIT_NS / DDG_CLK_NS;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [1:0] size;
    } ddg_mreq_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
        logic no_crc;
    } ddg_byte_t;
endpackage

// *** hdl/ddg_dma.sv ***
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - descriptor is 16..512 bytes with at most 63 address/length pairs
// - link at offset 0, header at 4, fragment n at n*8 and n*8+4
// - zero link ends the list; nonzero link addresses the next descriptor
// - header bit 15 set suppresses checksum append, clear appends it
// - underrun ends frame with bad checksum if enabled, else abort
// - after all fragments, set header bit 16 in host memory always; the code skips this write for header bit 29 descriptors
// - header bit 27 requests transmit-done interrupt; errors always interrupt
// - header bit 29 skips fragments and goes to the link fetch
// - header read before data and again after; re-read bit 31 gives interrupt
// - fragments start at any byte; engine handles alignment itself
// - fragment length word bits 14:0 give the byte count
// - length bit 31 marks the last fragment, then go to next descriptor
// - start only with nonzero head, not paused, and no underrun
// - start needs burst room in burst mode, else empty fifo
// - idle after reset; host opens adapter before downloads
// - once open, nonzero head write starts processing there
// - on finish, update status then copy link into head pointer
// - nonzero poll setting and zero link: re-read link periodically
// - polled nonzero link resumes download at that address
// - pause finishes current descriptor, holds next until resume
// - head write ignored while head pointer is nonzero
// - head read triggers one immediate poll of the link
module ddg_dma
    import ddg_pkg::*;
#(
    parameter int FIFO_DEPTH = 2048,
    parameter int BURST_BYTES = 256
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory master, byte/word reads and word writes
    output ddg_mreq_t mreq,
    input wire logic mgnt,
    input wire logic mrvalid,
    input wire logic [31:0] mrdata,
    // transmit fifo
    output ddg_byte_t fifo_wr,
    input wire logic fifo_ready,
    input wire logic [15:0] fifo_free,
    input wire logic fifo_empty,
    // transmitter events
    input wire logic tx_done,
    input wire logic tx_error,
    input wire logic tx_underrun,
    output logic tx_force_bad_crc,
    output logic tx_abort
);
    // fifo_free is 16 bits wide, so deeper fifos cannot be reported
    if (BURST_BYTES < 1 || BURST_BYTES > FIFO_DEPTH || FIFO_DEPTH > 65535) begin : g_bad_size
        $error("ddg_dma: unsupported fifo or burst size");
    end

    typedef enum logic [3:0] {
        S_IDLE, S_WAIT_ROOM, S_HDR1, S_FADDR, S_FLEN, S_DATA,
        S_HDR2, S_HDR_WR, S_LINK, S_POLL_WAIT
    } ddg_state_t;

    ddg_state_t state_r;
    logic [31:0] head_r;
    logic [31:0] poll_r;
    logic open_r;
    logic pause_r;
    logic burst_mode_r;
    logic bad_crc_en_r;
    logic underrun_r;
    logic [2:0] evt_r;
    logic tx_irq_req_r;
    logic [31:0] hdr_r;
    logic [5:0] frag_r;
    logic [31:0] faddr_r;
    logic [14:0] fleft_r;
    logic flast_r;
    logic [31:0] pcnt_r;
    logic [15:0] ucnt_r;
    logic poll_kick_r;
    logic acc_r;
    logic rd_pend_r;

    // ==========================================================
    // apb slave, single-cycle answer
    // ==========================================================
    wire apb_set = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire apb_rd = psel && penable && !pwrite;
    wire mapped = paddr inside {DDG_REG_LIST_HEAD, DDG_REG_POLL, DDG_REG_CTRL,
                                DDG_REG_STATUS, DDG_REG_TXEVT};
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    wire head_wr = apb_wr && paddr == DDG_REG_LIST_HEAD;
    wire ctrl_wr = apb_wr && paddr == DDG_REG_CTRL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= DDG_RESET_WORD;
        end else if (clk_en && apb_set) begin
            case (paddr)
                DDG_REG_LIST_HEAD: prdata <= head_r;
                DDG_REG_POLL: prdata <= poll_r;
                DDG_REG_CTRL: prdata <= {28'h000_0000, burst_mode_r, 1'b0, pause_r, open_r};
                DDG_REG_STATUS: prdata <= {26'h000_0000, underrun_r, pause_r,
                                           state_r != S_IDLE, evt_r};
                DDG_REG_TXEVT: prdata <= {31'h0000_0000, tx_irq_req_r};
                default: prdata <= DDG_RESET_WORD;
            endcase
        end
    end

    // ==========================================================
    // control registers
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_r <= 1'b0;
            pause_r <= 1'b0;
            burst_mode_r <= 1'b0;
            bad_crc_en_r <= 1'b0;
            poll_r <= DDG_RESET_WORD;
        end else if (clk_en) begin
            if (ctrl_wr) begin
                open_r <= pwdata[DDG_CTRL_OPEN];
                burst_mode_r <= pwdata[DDG_CTRL_BURST_MODE];
                bad_crc_en_r <= pwdata[DDG_CTRL_BAD_CRC_EN];
                if (pwdata[DDG_CTRL_PAUSE])
                    pause_r <= 1'b1;
                else if (pwdata[DDG_CTRL_RESUME])
                    pause_r <= 1'b0;
            end
            if (apb_wr && paddr == DDG_REG_POLL)
                poll_r <= pwdata;
        end
    end

    // underrun: sticky, ends frame with bad checksum if enabled, else abort; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            underrun_r <= 1'b0;
            tx_force_bad_crc <= 1'b0;
            tx_abort <= 1'b0;
        end else if (clk_en) begin
            tx_force_bad_crc <= tx_underrun && bad_crc_en_r;
            tx_abort <= tx_underrun && !bad_crc_en_r;
            if (tx_underrun)
                underrun_r <= 1'b1;
            else if (ctrl_wr && pwdata[DDG_CTRL_CLR_UNDERRUN])
                underrun_r <= 1'b0;
        end
    end

    // event flags: write one to clear, hardware set wins
    wire dn_done_ev = state_r == S_HDR2 && mrvalid && mrdata[DDG_HDR_DN_IRQ];
    wire tx_done_ev = tx_done && tx_irq_req_r;
    wire st_wr = apb_wr && paddr == DDG_REG_STATUS;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_r <= 3'h0;
        end else if (clk_en) begin
            if (dn_done_ev)
                evt_r[DDG_ST_DN_DONE] <= 1'b1;
            else if (st_wr && pwdata[DDG_ST_DN_DONE])
                evt_r[DDG_ST_DN_DONE] <= 1'b0;
            if (tx_done_ev)
                evt_r[DDG_ST_TX_DONE] <= 1'b1;
            else if (st_wr && pwdata[DDG_ST_TX_DONE])
                evt_r[DDG_ST_TX_DONE] <= 1'b0;
            if (tx_error)
                evt_r[DDG_ST_TX_ERR] <= 1'b1;
            else if (st_wr && pwdata[DDG_ST_TX_ERR])
                evt_r[DDG_ST_TX_ERR] <= 1'b0;
        end
    end

    // ==========================================================
    // download engine
    // ==========================================================
    // room check before each descriptor, burst size or empty fifo
    wire room_ok = burst_mode_r ? (fifo_free >= 16'(BURST_BYTES)) : fifo_empty;
    wire can_start = head_r != 32'h0000_0000 && !pause_r && !underrun_r
                     && open_r;
    wire poll_due = (pcnt_r == 32'h0000_0000) || poll_kick_r;
    // byte-wide reads make any start address legal; simple over fast
    wire [1:0] lane = faddr_r[1:0];

    always_comb begin
        mreq = '0;
        mreq.req = acc_r;
        mreq.size = 2'd2;
        case (state_r)
            S_HDR1, S_HDR2: mreq.addr = head_r + DDG_OFS_HDR;
            S_FADDR: mreq.addr = head_r + DDG_OFS_FRAG + {23'h00_0000, frag_r - 6'h01, 3'h0};
            S_FLEN: mreq.addr = head_r + DDG_OFS_FRAG + {23'h00_0000, frag_r - 6'h01, 3'h4};
            S_DATA: begin
                mreq.addr = faddr_r;
                mreq.size = 2'd0;
            end
            S_HDR_WR: begin
                mreq.we = 1'b1;
                mreq.addr = head_r + DDG_OFS_HDR;
                mreq.wdata = hdr_r | (32'h0000_0001 << DDG_HDR_DONE);
            end
            S_LINK, S_POLL_WAIT: mreq.addr = head_r + DDG_OFS_LINK;
            default: mreq.addr = DDG_RESET_WORD;
        endcase
    end

    wire last_frag = mrdata[DDG_LEN_LAST] || frag_r == 6'(DDG_MAX_FRAGS);
    wire data_ok = mrvalid && fifo_ready;

    // a granted read may answer many cycles later; no new request before its data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_pend_r <= 1'b0;
        end else if (clk_en) begin
            if (mgnt && !mreq.we)
                rd_pend_r <= 1'b1;
            else if (mrvalid)
                rd_pend_r <= 1'b0;
        end
    end
    wire bus_free = !acc_r && !rd_pend_r && !mrvalid;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
            head_r <= DDG_RESET_WORD;
            acc_r <= 1'b0;
            hdr_r <= DDG_RESET_WORD;
            frag_r <= 6'h00;
            faddr_r <= DDG_RESET_WORD;
            fleft_r <= 15'h0000;
            flast_r <= 1'b0;
            tx_irq_req_r <= 1'b0;
            fifo_wr <= '0;
        end else if (clk_en) begin
            fifo_wr.valid <= 1'b0;
            if (mgnt)
                acc_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (head_wr && head_r == 32'h0000_0000 && open_r)
                        head_r <= pwdata;
                    if (can_start) begin
                        state_r <= S_WAIT_ROOM;
                    end
                end
                S_WAIT_ROOM: if (room_ok) begin
                    state_r <= S_HDR1;
                    acc_r <= 1'b1;
                end
                S_HDR1: if (mrvalid) begin
                    hdr_r <= mrdata;
                    tx_irq_req_r <= mrdata[DDG_HDR_TX_IRQ];
                    frag_r <= 6'h01;
                    acc_r <= 1'b1;
                    state_r <= mrdata[DDG_HDR_NO_PAYLOAD] ? S_LINK : S_FADDR;
                end
                S_FADDR: if (mrvalid) begin
                    faddr_r <= mrdata;
                    acc_r <= 1'b1;
                    state_r <= S_FLEN;
                end
                S_FLEN: if (mrvalid) begin
                    fleft_r <= mrdata[DDG_HDR_LEN_MSB:0];
                    flast_r <= last_frag;
                    acc_r <= 1'b1;
                    state_r <= mrdata[DDG_HDR_LEN_MSB:0] != 15'h0000 ? S_DATA
                             : (last_frag ? S_HDR2 : S_FADDR);
                    // an empty fragment must still advance, or the same pair is read forever
                    if (mrdata[DDG_HDR_LEN_MSB:0] == 15'h0000)
                        frag_r <= frag_r + 6'h01;
                end
                S_DATA: begin
                    if (bus_free)
                        acc_r <= fifo_ready;
                    if (data_ok) begin
                        fifo_wr.valid <= 1'b1;
                        fifo_wr.data <= mrdata[8*lane +: 8];
                        fifo_wr.no_crc <= hdr_r[DDG_HDR_NO_CRC];
                        fifo_wr.last <= flast_r && fleft_r == 15'h0001;
                        faddr_r <= faddr_r + 32'h0000_0001;
                        fleft_r <= fleft_r - 15'h0001;
                        acc_r <= 1'b1;
                        if (fleft_r == 15'h0001) begin
                            frag_r <= frag_r + 6'h01;
                            state_r <= flast_r ? S_HDR2 : S_FADDR;
                        end
                    end
                end
                S_HDR2: if (mrvalid) begin
                    acc_r <= 1'b1;
                    state_r <= S_HDR_WR;
                end
                S_HDR_WR: if (mgnt) begin
                    acc_r <= 1'b1;
                    state_r <= S_LINK;
                end
                S_LINK, S_POLL_WAIT: begin
                    if (state_r == S_POLL_WAIT && bus_free && poll_due)
                        acc_r <= 1'b1;
                    if (mrvalid) begin
                        if (mrdata != 32'h0000_0000) begin
                            head_r <= mrdata;
                            state_r <= S_IDLE;
                        end else if (poll_r != 32'h0000_0000) begin
                            state_r <= S_POLL_WAIT;
                        end else begin
                            head_r <= DDG_RESET_WORD;
                            state_r <= S_IDLE;
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // poll interval counter and head-read kick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt_r <= DDG_RESET_WORD;
            ucnt_r <= 16'h0000;
            poll_kick_r <= 1'b0;
        end else if (clk_en) begin
            if (apb_rd && paddr == DDG_REG_LIST_HEAD)
                poll_kick_r <= 1'b1;
            else if (state_r == S_POLL_WAIT && mrvalid)
                poll_kick_r <= 1'b0;
            if (state_r != S_POLL_WAIT || mrvalid) begin
                pcnt_r <= poll_r;
                ucnt_r <= 16'h0000;
            end else if (pcnt_r != 32'h0000_0000) begin
                if (ucnt_r == 16'(DDG_POLL_UNIT_CYC - 1)) begin
                    ucnt_r <= 16'h0000;
                    pcnt_r <= pcnt_r - 32'h0000_0001;
                end else begin
                    ucnt_r <= ucnt_r + 16'h0001;
                end
            end
        end
    end
endmodule // ddg_dma

// *** dv/ddg_dma_assertions.sv ***
`timescale 1ns/1ps
// ==========
// port checker for the gather engine
module ddg_dma_assertions
    import ddg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    // memory and fifo
    input wire ddg_mreq_t mreq,
    input wire logic mgnt,
    input wire logic mrvalid,
    input wire ddg_byte_t fifo_wr,
    // transmitter
    input wire logic tx_underrun,
    input wire logic tx_force_bad_crc,
    input wire logic tx_abort
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_release;
        $rose(presetn);
    endsequence
    sequence s_waiting;
        mreq.req && !mgnt && clk_en;
    endsequence
    property p_quiet;
        s_release |-> !mreq.req [*2];
    endproperty
    a_quiet: assert property (p_quiet) else $error("request right after reset");
    property p_hold;
        s_waiting |=> mreq.req && $stable(mreq.addr) && $stable(mreq.we);
    endproperty
    a_hold: assert property (p_hold) else $error("request moved before grant");
    property p_wback;
        mreq.req && mreq.we |-> mreq.wdata[DDG_HDR_DONE] && mreq.addr[2:0] == 3'h4;
    endproperty
    a_wback: assert property (p_wback) else $error("write is not a done header");
    property p_src;
        fifo_wr.valid |-> $past(mrvalid);
    endproperty
    a_src: assert property (p_src) else $error("fifo byte without read data");
    property p_pulse;
        fifo_wr.valid |=> !fifo_wr.valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("byte pulse too long");
    property p_end;
        tx_underrun && clk_en |=> tx_force_bad_crc != tx_abort;
    endproperty
    a_end: assert property (p_end) else $error("underrun frame not ended once");
    property p_cause;
        tx_force_bad_crc || tx_abort |-> $past(tx_underrun);
    endproperty
    a_cause: assert property (p_cause) else $error("frame end without underrun");
    // unaligned offsets inside the map also flag pslverr, but only offsets above it are checked
    property p_unmapped;
        psel && penable && paddr > 8'h13 |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
endmodule // ddg_dma_assertions

bind ddg_dma ddg_dma_assertions u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .paddr,
    .pslverr, .mreq, .mgnt, .mrvalid, .fifo_wr, .tx_underrun, .tx_force_bad_crc, .tx_abort);

// *** dv/ddg_mem_model.sv ***
`timescale 1ns/1ps
// ==========
// host memory: one request at a time, optional wait states
module ddg_mem_model
    import ddg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pace
    input wire logic slow,
    // memory port
    input wire ddg_mreq_t mreq,
    output logic mgnt,
    output logic mrvalid,
    output logic [31:0] mrdata
);
    logic [31:0] mem [0:255];
    logic [1:0] wait_r;
    logic pend_r;
    logic [7:0] idx_r;
    initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mgnt <= 1'b0;
            mrvalid <= 1'b0;
            pend_r <= 1'b0;
            wait_r <= 2'h0;
            mrdata <= 32'h0;
        end else begin
            mgnt <= 1'b0;
            mrvalid <= 1'b0;
            if (pend_r) begin
                mrvalid <= 1'b1;
                mrdata <= mem[idx_r];
                pend_r <= 1'b0;
            end else begin
                // stale data flips every cycle so a late sample cannot match
                mrdata <= ~mrdata;
                if (mreq.req && !mgnt) begin
                    if (slow && wait_r != 2'h3) begin
                        wait_r <= wait_r + 2'h1;
                    end else begin
                        wait_r <= 2'h0;
                        mgnt <= 1'b1;
                        if (mreq.we) begin
                            mem[mreq.addr[9:2]] <= mreq.wdata;
                        end else begin
                            pend_r <= 1'b1;
                            idx_r <= mreq.addr[9:2];
                        end
                    end
                end
            end
        end
    end
endmodule // ddg_mem_model

// *** dv/ddg_dma_test.sv ***
`timescale 1ns/1ps
// ==========
// bench for the gather engine
module ddg_dma_test;
    import ddg_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic tx_done = 1'b0, tx_error = 1'b0, tx_underrun = 1'b0, fifo_empty = 1'b1, slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, mrdata, rd;
    logic pready, pslverr, mgnt, mrvalid, tx_force_bad_crc, tx_abort, err;
    logic [15:0] fifo_free = 16'h0800, lfsr = 16'h0041;
    logic [9:0] got;
    logic [9:0] expq[$];
    ddg_mreq_t mreq;
    ddg_byte_t fifo_wr;
    int n_fail = 0, compares = 0;
    always #2.5 pclk = ~pclk;
    ddg_dma #(.FIFO_DEPTH(64), .BURST_BYTES(16)) dut (.pclk, .presetn, .clk_en(1'b1), .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mreq, .mgnt, .mrvalid,
        .mrdata, .fifo_wr, .fifo_ready(1'b1), .fifo_free, .fifo_empty, .tx_done, .tx_error,
        .tx_underrun, .tx_force_bad_crc, .tx_abort);
    ddg_mem_model host (.pclk, .presetn, .slow, .mreq, .mgnt, .mrvalid, .mrdata);
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic stuck(input string what);
        chk(what, 1'b1, 1'b0);
        close_out();
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            if (++k > 20) stuck("apb wait");
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one fragment with the last flag; bytes noted unless the header says no payload
    task automatic desc(input logic [9:0] b, input logic [31:0] link, hdr, input int nb,
        input logic [9:0] fa);
        logic [9:0] ba;
        host.mem[b[9:2]] = link;
        host.mem[b[9:2] + 8'd1] = hdr | nb;
        host.mem[b[9:2] + 8'd2] = {22'h0, fa};
        host.mem[b[9:2] + 8'd3] = 32'h8000_0000 | nb;
        for (int i = 0; i < nb; i++) begin
            ba = fa + i[9:0];
            lfsr = step(lfsr);
            host.mem[ba[9:2]][ba[1:0]*8 +: 8] = lfsr[7:0];
            if (!hdr[29]) expq.push_back({lfsr[7:0], i == nb - 1, hdr[15]});
        end
        slow <= lfsr[4];
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge pclk);
            chk("held off", mreq.req, 1'b0);
        end
    endtask
    task automatic drain;
        int j;
        j = 0;
        do begin
            if (++j > 500) stuck("download wait");
            apb(1'b0, DDG_REG_STATUS, 32'h0);
        end while (expq.size() != 0 || rd[DDG_ST_BUSY] !== 1'b0);
    endtask
    task automatic wait_q(input int n);
        repeat (n) if (expq.size() != 0) @(posedge pclk);
        if (expq.size() != 0) stuck("byte wait");
    endtask
    // transmitter event, then the frame-end outputs one cycle on
    task automatic pulse(input logic [2:0] s);
        @(posedge pclk);
        {tx_done, tx_error, tx_underrun} <= s;
        @(posedge pclk);
        {tx_done, tx_error, tx_underrun} <= 3'b000;
        @(posedge pclk);
        rd = {30'h0, tx_force_bad_crc, tx_abort};
    endtask
    always @(posedge pclk) begin
        if (fifo_wr.valid === 1'b1) begin
            got = {fifo_wr.data, fifo_wr.last, fifo_wr.no_crc};
            if (expq.size() == 0)
                chk("stray byte", 1'b1, 1'b0);
            else
                chk("fifo byte", got, expq.pop_front());
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, DDG_REG_STATUS, 32'h0);
        chk("reset status", rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", err, 1'b1);
        chk("unmapped data", rd, 32'h0);
        desc(10'h040, 32'h0, 32'h8800_0000, 5, 10'h201);
        apb(1'b1, DDG_REG_LIST_HEAD, 32'h40);
        quiet(20);
        apb(1'b0, DDG_REG_LIST_HEAD, 32'h0);
        chk("head before open", rd, 32'h0);
        fifo_empty <= 1'b0;
        apb(1'b1, DDG_REG_CTRL, 32'h1);
        apb(1'b1, DDG_REG_LIST_HEAD, 32'h40);
        apb(1'b1, DDG_REG_LIST_HEAD, 32'h80);
        quiet(20);
        fifo_empty <= 1'b1;
        drain();
        chk("done bit", host.mem[17][DDG_HDR_DONE], 1'b1);
        chk("ignored head", host.mem[33][DDG_HDR_DONE], 1'b0);
        chk("dn irq", rd[DDG_ST_DN_DONE], 1'b1);
        apb(1'b0, DDG_REG_LIST_HEAD, 32'h0);
        chk("head after list end", rd, 32'h0);
        pulse(3'b100);
        apb(1'b0, DDG_REG_STATUS, 32'h0);
        chk("tx done irq", rd[DDG_ST_TX_DONE], 1'b1);
        $display("test single packet done");
        apb(1'b1, DDG_REG_STATUS, 32'h7);
        apb(1'b1, DDG_REG_CTRL, 32'hB);
        fifo_free <= 16'd15;
        desc(10'h040, 32'h0, 32'h0000_8000, 4, 10'h2F3);
        apb(1'b1, DDG_REG_LIST_HEAD, 32'h40);
        quiet(20);
        apb(1'b0, DDG_REG_STATUS, 32'h0);
        chk("paused flag", rd[DDG_ST_PAUSED], 1'b1);
        chk("idle while paused", rd[DDG_ST_BUSY], 1'b0);
        apb(1'b1, DDG_REG_CTRL, 32'hD);
        quiet(20);
        fifo_free <= 16'd16;
        drain();
        chk("no dn irq", rd[DDG_ST_DN_DONE], 1'b0);
        pulse(3'b100);
        pulse(3'b010);
        apb(1'b0, DDG_REG_STATUS, 32'h0);
        chk("tx done masked", rd[DDG_ST_TX_DONE], 1'b0);
        chk("tx error irq", rd[DDG_ST_TX_ERR], 1'b1);
        $display("test pause and burst room done");
        apb(1'b1, DDG_REG_CTRL, 32'h21);
        pulse(3'b001);
        chk("bad checksum end", rd, 32'h2);
        desc(10'h040, 32'h0, 32'h0, 2, 10'h311);
        apb(1'b1, DDG_REG_LIST_HEAD, 32'h40);
        quiet(20);
        apb(1'b0, DDG_REG_STATUS, 32'h0);
        chk("underrun flag", rd[DDG_ST_UNDERRUN], 1'b1);
        apb(1'b1, DDG_REG_CTRL, 32'h11);
        drain();
        pulse(3'b001);
        chk("abort end", rd, 32'h1);
        apb(1'b1, DDG_REG_CTRL, 32'h11);
        $display("test underrun done");
        apb(1'b1, DDG_REG_POLL, 32'h1);
        desc(10'h040, 32'h0, 32'h2000_0000, 1, 10'h3F0);
        apb(1'b1, DDG_REG_LIST_HEAD, 32'h40);
        repeat (100) @(posedge pclk);
        desc(10'h0C0, 32'h0, 32'h0, 3, 10'h355);
        host.mem[16] = 32'hC0;
        wait_q(400);
        apb(1'b1, DDG_REG_POLL, 32'hFF);
        repeat (150) @(posedge pclk);
        desc(10'h100, 32'h0, 32'h0, 2, 10'h3A0);
        host.mem[48] = 32'h100;
        apb(1'b0, DDG_REG_LIST_HEAD, 32'h0);
        wait_q(150);
        $display("test polling done");
        close_out();
    end
endmodule // ddg_dma_test
